// ===== pkg/pll_cfg_pkg.sv
// Constants for the synthesizer calibration and detector configuration bank.
// Assumes one 125 MHz clock that stands in for the crystal reference.
package pll_cfg_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam int ADDR_W = 6;
	localparam int DATA_W = 24;
	localparam logic [5:0] ADDR_TUNE = 6'h05;
	localparam logic [5:0] ADDR_VCO_CAL = 6'h0A;
	localparam logic [5:0] ADDR_PD_CTRL = 6'h0B;
	localparam logic [5:0] ADDR_EXACT = 6'h0C;
	localparam logic [23:0] RESET_VCO_CAL = 24'h002205;
	localparam logic [23:0] RESET_PD_CTRL = 24'h07C061;
	localparam logic [23:0] RESET_EXACT = 24'h000000;
	// ----------------------------------------
	// Calibration register fields
	// ----------------------------------------
	localparam int CAL_RES_LSB = 0;
	localparam int CAL_CURVE_LSB = 3;
	localparam int CAL_WAIT_LSB = 6;
	localparam int CAL_SAR_LSB = 8;
	localparam int CAL_FORCE_BIT = 10;
	localparam int CAL_BYPASS_BIT = 11;
	localparam int CAL_NO_TRIG_BIT = 12;
	localparam int CAL_CLKSEL_LSB = 13;
	localparam int CAL_FALL_BIT = 15;
	localparam int CAL_RDIV_BYP_BIT = 16;
	// ----------------------------------------
	// Detector and exact-frequency register fields
	// ----------------------------------------
	localparam int PD_DELAY_LSB = 0;
	localparam int PD_SHORT_BIT = 3;
	localparam int PD_INVERT_BIT = 4;
	localparam int DETECTOR_UP_OUTPUT_ENABLE_BIT = 5;
	localparam int DETECTOR_DOWN_OUTPUT_ENABLE_BIT = 6;
	localparam int PD_CSP_LSB = 7;
	localparam int PD_FORCE_UP_BIT = 9;
	localparam int PD_FORCE_DN_BIT = 10;
	localparam int PD_MID_RAIL_BIT = 11;
	localparam int PD_GATE_LSB = 17;
	localparam int EXACT_W = 14;
	localparam logic [13:0] EXACT_MIN_ON = 14'h0002;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam logic [6:0] STARTUP_WAIT = 7'h64;
	localparam int REF_CLOCK_KHZ = 125000;
	localparam int FSM_CLOCK_MAX_KHZ = 50000;
	localparam logic [15:0] CSP_PS_1 = 16'h1518;
	localparam logic [15:0] CSP_PS_2 = 16'h3840;
	localparam logic [15:0] CSP_PS_3 = 16'h5E24;

	function automatic logic [8:0] measure_cycles(input logic [2:0] code);
		unique case (code)
			3'h0: measure_cycles = 9'h001;
			3'h1: measure_cycles = 9'h002;
			3'h2: measure_cycles = 9'h004;
			3'h3: measure_cycles = 9'h008;
			3'h4: measure_cycles = 9'h020;
			3'h5: measure_cycles = 9'h040;
			3'h6: measure_cycles = 9'h080;
			3'h7: measure_cycles = 9'h100;
		endcase
	endfunction : measure_cycles

	function automatic logic [5:0] fsm_divide(input logic [1:0] code);
		unique case (code)
			2'h0: fsm_divide = 6'h01;
			2'h1: fsm_divide = 6'h04;
			2'h2: fsm_divide = 6'h10;
			2'h3: fsm_divide = 6'h20;
		endcase
	endfunction : fsm_divide
endpackage : pll_cfg_pkg

// ===== rtl/fsm_tick_gen.sv
// Divides the reference into the calibration state machine tick.
// Assumes the select comes from a register on the same clock.
module fsm_tick_gen
	import pll_cfg_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic [1:0] ratio_sel_i,
	output logic tick_o
);
	logic [5:0] count;

	// Ratio change takes effect on the next edge, mid-count; a shrinking ratio wraps at once
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			count <= 6'h00;
			tick_o <= 1'b0;
		end
		else if (count >= 6'(fsm_divide(ratio_sel_i) - 6'h01))
		begin
			count <= 6'h00;
			tick_o <= 1'b1;
		end
		else
		begin
			count <= 6'(count + 6'h01);
			tick_o <= 1'b0;
		end
	end
endmodule : fsm_tick_gen

// ===== rtl/pll_autocal_pd_config_regs.sv
// Calibration, phase detector and exact-frequency configuration registers,
// with the calibration wait/measure sequencer that they steer.
// Assumes a simple same-clock register port and same-clock calibration strobes.
//
// What this block does
// [RL1] Resolution code picks measurement length 1,2,4,8,32,64,128,256 cycles; reset 5.
// [RL2] Curve field: 0 off, 1..3 add curves, 4..7 subtract four..one.
// [RL3] Wait 100 FSM ticks at startup and after first n measurements.
// [RL4] Search step count is 8,7,6,5 for codes 0..3.
// [RL5] Force-curve uses tuning register value; bypass skips the search.
// [RL6] Writes to address 05h start a transfer unless bit 12 set.
// [RL7] FSM clock is reference over 1,4,16,32; keep it at most 50 MHz.
// [RL8] Bit 15 selects falling reference edge; needed before self test.
// [RL9] Bit 16 forces reference divider bypass.
// [RL10] Detector reset delay field, recommended and reset value 001.
// [RL11] Bit 3 ties detector inputs together, test only.
// [RL12] Bit 4 inverts detector polarity; clear is normal.
// [RL13] Bits 5 and 6 enable up and down outputs; both reset to one.
// [RL14] Cycle-slip code: off, 5.4 ns, 14.4 ns, 24.1 ns thresholds.
// [RL15] Bits 9,10,11 force pump up, down and mid rail.
// [RL16] Counter clock gating: off, below 128, below 1023, all on.
// [RL17] Channel count 0 or 1 disables exact mode; 2..16383 enables it.
// [RL18] Software writes reserved fields with their documented values.
// [RL19] Reset loads documented defaults; fields read back as written.
module pll_autocal_pd_config_regs
	import pll_cfg_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic reg_write_i,
	input wire logic [5:0] reg_addr_i,
	input wire logic [23:0] reg_wdata_i,
	input wire logic cal_start_i,
	input wire logic rdiv_cycle_i,
	output logic [23:0] reg_rdata_o,
	output logic tune_transfer_o,
	output logic [8:0] meas_length_o,
	output logic signed [3:0] curve_offset_o,
	output logic [3:0] sar_steps_o,
	output logic force_curve_o,
	output logic tuning_bypass_o,
	output logic fsm_clock_fast_o,
	output logic fsm_falling_edge_o,
	output logic rdiv_bypass_o,
	output logic cal_waiting_o,
	output logic cal_measuring_o,
	output logic cal_done_o,
	output logic [2:0] detector_reset_delay_o,
	output logic detector_inputs_short_o,
	output logic detector_polarity_invert_o,
	output logic detector_up_output_enable_o,
	output logic detector_down_output_enable_o,
	output logic cycle_slip_guard_enable_o,
	output logic [15:0] cycle_slip_threshold_ps_o,
	output logic force_pump_up_o,
	output logic force_pump_down_o,
	output logic force_mid_rail_o,
	output logic [1:0] modulus_counter_clock_gate_o,
	output logic modulus_counter_on_o,
	output logic exact_frequency_enable_o,
	output logic [13:0] exact_frequency_channels_o
);
	typedef enum logic [1:0] {CAL_IDLE, CAL_START_WAIT, CAL_MEASURE, CAL_STEP_WAIT} cal_state_t;

	logic [23:0] vco_calibration_config;
	logic [23:0] phase_detector_control;
	logic [23:0] exact_frequency_channels;
	cal_state_t cal_state;
	logic [6:0] wait_count;
	logic [8:0] meas_count;
	logic [3:0] step_count;
	logic fsm_tick;
	logic [1:0] clk_sel;
	logic [1:0] wait_sel;

	assign clk_sel = vco_calibration_config[CAL_CLKSEL_LSB +: 2];
	assign wait_sel = vco_calibration_config[CAL_WAIT_LSB +: 2];

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			vco_calibration_config <= RESET_VCO_CAL; // RL19 RL1
			phase_detector_control <= RESET_PD_CTRL; // RL10 RL13
			exact_frequency_channels <= RESET_EXACT;
		end
		else if (reg_write_i)
		begin
			// All bits stored as written, reserved ones included
			unique case (reg_addr_i)
				ADDR_VCO_CAL: vco_calibration_config <= reg_wdata_i; // RL19
				ADDR_PD_CTRL: phase_detector_control <= reg_wdata_i; // RL19
				ADDR_EXACT: exact_frequency_channels <= reg_wdata_i; // RL19
				default: ;
			endcase
		end
	end

	// Read data follows the address by one cycle; unmapped reads zero
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			reg_rdata_o <= 24'h000000;
		else
		begin
			unique case (reg_addr_i)
				ADDR_VCO_CAL: reg_rdata_o <= vco_calibration_config; // RL19
				ADDR_PD_CTRL: reg_rdata_o <= phase_detector_control; // RL19
				ADDR_EXACT: reg_rdata_o <= exact_frequency_channels; // RL19
				default: reg_rdata_o <= 24'h000000;
			endcase
		end
	end

	// The tuning register itself lives elsewhere; only its write is watched
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
			tune_transfer_o <= 1'b0;
		else
			tune_transfer_o <= reg_write_i && reg_addr_i == ADDR_TUNE
				&& !vco_calibration_config[CAL_NO_TRIG_BIT]; // RL6
	end

	// ----------------------------------------
	// Calibration controls
	// ----------------------------------------
	always_ff @(posedge clock_i)
	begin
		meas_length_o <= measure_cycles(vco_calibration_config[CAL_RES_LSB +: 3]); // RL1
		// Field is already two's complement: 4..7 mean -4..-1
		curve_offset_o <= signed'({vco_calibration_config[CAL_CURVE_LSB + 2],
			vco_calibration_config[CAL_CURVE_LSB +: 3]}); // RL2
		sar_steps_o <= 4'(4'h8 - {2'b00, vco_calibration_config[CAL_SAR_LSB +: 2]}); // RL4
		force_curve_o <= vco_calibration_config[CAL_FORCE_BIT]; // RL5
		tuning_bypass_o <= vco_calibration_config[CAL_BYPASS_BIT]; // RL5
		fsm_falling_edge_o <= vco_calibration_config[CAL_FALL_BIT]; // RL8
		rdiv_bypass_o <= vco_calibration_config[CAL_RDIV_BYP_BIT]; // RL9
		// Flags a select that runs the FSM clock above its limit
		fsm_clock_fast_o <= REF_CLOCK_KHZ > FSM_CLOCK_MAX_KHZ * int'(fsm_divide(clk_sel)); // RL7
	end

	fsm_tick_gen u_tick (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.ratio_sel_i(clk_sel), // RL7
		.tick_o(fsm_tick)
	);

	// ----------------------------------------
	// Calibration sequencer
	// ----------------------------------------
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			cal_state <= CAL_IDLE;
			wait_count <= 7'h00;
			meas_count <= 9'h000;
			step_count <= 4'h0;
			cal_done_o <= 1'b0;
		end
		else
		begin
			cal_done_o <= 1'b0;
			unique case (cal_state)
				CAL_IDLE:
					if (cal_start_i)
					begin
						if (vco_calibration_config[CAL_BYPASS_BIT])
							cal_done_o <= 1'b1; // RL5
						else
						begin
							cal_state <= CAL_START_WAIT; // RL3
							wait_count <= 7'h00;
						end
					end
				CAL_START_WAIT, CAL_STEP_WAIT:
					if (fsm_tick)
					begin
						if (wait_count == 7'(STARTUP_WAIT - 7'h01))
						begin
							if (cal_state == CAL_START_WAIT)
								step_count <= 4'h0;
							cal_state <= CAL_MEASURE; // RL3
							meas_count <= 9'h000;
						end
						else
							wait_count <= 7'(wait_count + 7'h01);
					end
				CAL_MEASURE:
					if (rdiv_cycle_i)
					begin
						if (meas_count == 9'(meas_length_o - 9'h001))
						begin
							meas_count <= 9'h000;
							step_count <= 4'(step_count + 4'h1);
							if (4'(step_count + 4'h1) == sar_steps_o) // RL4
							begin
								cal_state <= CAL_IDLE;
								cal_done_o <= 1'b1;
							end
							else if (step_count < {2'b00, wait_sel})
							begin
								cal_state <= CAL_STEP_WAIT; // RL3
								wait_count <= 7'h00;
							end
						end
						else
							meas_count <= 9'(meas_count + 9'h001); // RL1
					end
			endcase
		end
	end

	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			cal_waiting_o <= 1'b0;
			cal_measuring_o <= 1'b0;
		end
		else
		begin
			cal_waiting_o <= cal_state == CAL_START_WAIT || cal_state == CAL_STEP_WAIT;
			cal_measuring_o <= cal_state == CAL_MEASURE;
		end
	end

	// ----------------------------------------
	// Detector and exact-frequency controls
	// ----------------------------------------
	always_ff @(posedge clock_i)
	begin
		detector_reset_delay_o <= phase_detector_control[PD_DELAY_LSB +: 3]; // RL10
		detector_inputs_short_o <= phase_detector_control[PD_SHORT_BIT]; // RL11
		detector_polarity_invert_o <= phase_detector_control[PD_INVERT_BIT]; // RL12
		detector_up_output_enable_o <= phase_detector_control[DETECTOR_UP_OUTPUT_ENABLE_BIT]; // RL13
		detector_down_output_enable_o <= phase_detector_control[DETECTOR_DOWN_OUTPUT_ENABLE_BIT]; // RL13
		cycle_slip_guard_enable_o <= phase_detector_control[PD_CSP_LSB +: 2] != 2'h0; // RL14
		unique case (phase_detector_control[PD_CSP_LSB +: 2])
			2'h0: cycle_slip_threshold_ps_o <= 16'h0000;
			2'h1: cycle_slip_threshold_ps_o <= CSP_PS_1; // RL14
			2'h2: cycle_slip_threshold_ps_o <= CSP_PS_2; // RL14
			2'h3: cycle_slip_threshold_ps_o <= CSP_PS_3; // RL14
		endcase
		force_pump_up_o <= phase_detector_control[PD_FORCE_UP_BIT]; // RL15
		force_pump_down_o <= phase_detector_control[PD_FORCE_DN_BIT]; // RL15
		force_mid_rail_o <= phase_detector_control[PD_MID_RAIL_BIT]; // RL15
		modulus_counter_clock_gate_o <= phase_detector_control[PD_GATE_LSB +: 2]; // RL16
		modulus_counter_on_o <= phase_detector_control[PD_GATE_LSB +: 2] != 2'h0; // RL16
		exact_frequency_channels_o <= exact_frequency_channels[EXACT_W-1:0]; // RL17
		exact_frequency_enable_o <= exact_frequency_channels[EXACT_W-1:0] >= EXACT_MIN_ON; // RL17
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	meas_length_a: assert property (@(posedge clock_i) disable iff (rst_i) // RL1
		!$past(rst_i) |-> meas_length_o == measure_cycles($past(vco_calibration_config[2:0])))
		else $error("measurement length does not follow resolution code");

	curve_offset_a: assert property (@(posedge clock_i) disable iff (rst_i) // RL2
		!$past(rst_i) |-> curve_offset_o == signed'({$past(vco_calibration_config[5]),
			$past(vco_calibration_config[5:3])}))
		else $error("curve offset wrong");

	startup_wait_a: assert property (@(posedge clock_i) disable iff (rst_i) // RL3
		$fell(cal_waiting_o) |-> $past(wait_count, 2) == 7'h63)
		else $error("wait ended before 100 ticks");

	sar_steps_a: assert property (@(posedge clock_i) disable iff (rst_i) // RL4
		!$past(rst_i) |-> sar_steps_o == 4'(4'h8 - {2'b00, $past(vco_calibration_config[9:8])}))
		else $error("search step count wrong");

	bypass_done_a: assert property (@(posedge clock_i) disable iff (rst_i) // RL5
		cal_state == CAL_IDLE && cal_start_i && vco_calibration_config[11]
		|=> cal_done_o ##1 !cal_waiting_o && !cal_measuring_o)
		else $error("bypass did not skip the search");

	tune_trigger_a: assert property (@(posedge clock_i) disable iff (rst_i) // RL6
		reg_write_i && reg_addr_i == 6'h05 |=> tune_transfer_o == !$past(vco_calibration_config[12]))
		else $error("tuning transfer trigger wrong");

	up_enable_a: assert property (@(posedge clock_i) disable iff (rst_i) // RL13
		!$past(rst_i) |-> detector_up_output_enable_o == $past(phase_detector_control[5]))
		else $error("up output enable does not follow bit 5");

	slip_guard_a: assert property (@(posedge clock_i) disable iff (rst_i) // RL14
		cycle_slip_guard_enable_o |-> cycle_slip_threshold_ps_o != 16'h0000)
		else $error("cycle slip guard without threshold");

	exact_enable_a: assert property (@(posedge clock_i) disable iff (rst_i) // RL17
		!$past(rst_i) |-> exact_frequency_enable_o == ($past(exact_frequency_channels[13:0]) > 14'h0001))
		else $error("exact frequency enable wrong");

	readback_a: assert property (@(posedge clock_i) disable iff (rst_i) // RL19
		reg_write_i && reg_addr_i == 6'h0B ##1 reg_addr_i == 6'h0B && !reg_write_i
		|=> reg_rdata_o == $past(reg_wdata_i, 2))
		else $error("detector register read back differs from write");

	force_bypass_a: assert property (@(posedge clock_i) disable iff (rst_i) // RL5
		!$past(rst_i) |-> {tuning_bypass_o, force_curve_o}
			== $past(vco_calibration_config[11:10]))
		else $error("force curve or bypass does not follow its bit");

	// Reference clock is 125 MHz, so only the undivided select exceeds the limit
	clock_limit_a: assert property (@(posedge clock_i) disable iff (rst_i) // RL7
		!$past(rst_i) |-> fsm_clock_fast_o
			== ($past(vco_calibration_config[14:13]) == 2'h0))
		else $error("clock limit flag wrong for the selected divider");

	falling_edge_a: assert property (@(posedge clock_i) disable iff (rst_i) // RL8
		!$past(rst_i) |-> fsm_falling_edge_o == $past(vco_calibration_config[15]))
		else $error("falling edge select does not follow bit 15");

	rdiv_bypass_a: assert property (@(posedge clock_i) disable iff (rst_i) // RL9
		!$past(rst_i) |-> rdiv_bypass_o == $past(vco_calibration_config[16]))
		else $error("divider bypass does not follow bit 16");

	reset_delay_a: assert property (@(posedge clock_i) disable iff (rst_i) // RL10
		!$past(rst_i) |-> detector_reset_delay_o == $past(phase_detector_control[2:0]))
		else $error("detector reset delay does not follow its field");

	inputs_short_a: assert property (@(posedge clock_i) disable iff (rst_i) // RL11
		!$past(rst_i) |-> detector_inputs_short_o == $past(phase_detector_control[3]))
		else $error("input short does not follow bit 3");

	polarity_invert_a: assert property (@(posedge clock_i) disable iff (rst_i) // RL12
		!$past(rst_i) |-> detector_polarity_invert_o == $past(phase_detector_control[4]))
		else $error("polarity invert does not follow bit 4");

	down_enable_a: assert property (@(posedge clock_i) disable iff (rst_i) // RL13
		!$past(rst_i) |-> detector_down_output_enable_o == $past(phase_detector_control[6]))
		else $error("down output enable does not follow bit 6");

	slip_threshold_a: assert property (@(posedge clock_i) disable iff (rst_i) // RL14
		!$past(rst_i) && $past(phase_detector_control[8:7]) == 2'h2
		|-> cycle_slip_threshold_ps_o == 16'h3840 && cycle_slip_guard_enable_o)
		else $error("middle cycle slip threshold wrong");

	pump_force_a: assert property (@(posedge clock_i) disable iff (rst_i) // RL15
		!$past(rst_i) |-> {force_mid_rail_o, force_pump_down_o, force_pump_up_o}
			== $past(phase_detector_control[11:9]))
		else $error("pump force controls do not follow bits 9 to 11");

	counter_gate_a: assert property (@(posedge clock_i) disable iff (rst_i) // RL16
		!$past(rst_i) |-> modulus_counter_clock_gate_o == $past(phase_detector_control[18:17])
			&& modulus_counter_on_o == ($past(phase_detector_control[18:17]) != 2'h0))
		else $error("counter clock gating wrong");

	reset_defaults_a: assert property (@(posedge clock_i) disable iff (rst_i) // RL19
		$past(rst_i) |-> vco_calibration_config == RESET_VCO_CAL
			&& phase_detector_control == RESET_PD_CTRL
			&& exact_frequency_channels == RESET_EXACT)
		else $error("register defaults wrong after reset");
endmodule : pll_autocal_pd_config_regs

// ===== verification/pll_autocal_pd_config_regs_tb.sv
// Self-checking bench for the calibration and detector configuration bank.
// Assumes the package constants and the registered read and decode timing of the port.
module pll_autocal_pd_config_regs_tb;
	import pll_cfg_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic reg_write_i = 1'b0;
	logic [5:0] reg_addr_i = 6'h00;
	logic [23:0] reg_wdata_i = 24'h000000;
	logic cal_start_i = 1'b0;
	logic rdiv_cycle_i = 1'b0;
	logic [23:0] rdata;
	logic tune_xfer;
	logic [8:0] meas_len;
	logic signed [3:0] curve;
	logic [3:0] sar;
	logic force_curve, bypass, fast, fall, rdiv_byp, waiting, measuring, done;
	logic [2:0] delay;
	logic shorted, invert, up_en, dn_en, guard_en, f_up, f_dn, mid, cnt_on, ex_en;
	logic [15:0] thr;
	logic [1:0] gate;
	logic [13:0] chans;
	int errors = 0;
	int check_count = 0;
	int cycles = 0;

	pll_autocal_pd_config_regs uut (.clock_i(clock_i), .rst_i(rst_i), .reg_write_i(reg_write_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .cal_start_i(cal_start_i),
		.rdiv_cycle_i(rdiv_cycle_i), .reg_rdata_o(rdata), .tune_transfer_o(tune_xfer),
		.meas_length_o(meas_len), .curve_offset_o(curve), .sar_steps_o(sar),
		.force_curve_o(force_curve), .tuning_bypass_o(bypass), .fsm_clock_fast_o(fast),
		.fsm_falling_edge_o(fall), .rdiv_bypass_o(rdiv_byp), .cal_waiting_o(waiting),
		.cal_measuring_o(measuring), .cal_done_o(done), .detector_reset_delay_o(delay),
		.detector_inputs_short_o(shorted), .detector_polarity_invert_o(invert),
		.detector_up_output_enable_o(up_en), .detector_down_output_enable_o(dn_en),
		.cycle_slip_guard_enable_o(guard_en), .cycle_slip_threshold_ps_o(thr),
		.force_pump_up_o(f_up), .force_pump_down_o(f_dn), .force_mid_rail_o(mid),
		.modulus_counter_clock_gate_o(gate), .modulus_counter_on_o(cnt_on),
		.exact_frequency_enable_o(ex_en), .exact_frequency_channels_o(chans));

	initial
	begin
		forever #4 clock_i = ~clock_i;
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
		check_count++;
		if (got !== exp)
		begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic check_range(input string what, input int lo, input int hi, input int got);
		check_count++;
		if (got < lo || got > hi)
		begin
			errors++;
			$display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask : check_range

	task automatic wr(input logic [5:0] a, input logic [23:0] d);
		@(posedge clock_i);
		reg_write_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clock_i);
		reg_write_i <= 1'b0;
		// Decodes land two edges after the strobe
		repeat (2) @(posedge clock_i);
		#1;
	endtask : wr

	task automatic rd(input logic [5:0] a, input logic [23:0] exp, input string what);
		@(posedge clock_i);
		reg_addr_i <= a;
		repeat (2) @(posedge clock_i);
		#1;
		check(what, exp, rdata);
	endtask : rd

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict

	// Slow divider-cycle pulses, one cycle in four
	always @(posedge clock_i)
	begin
		cycles <= cycles + 1;
		rdiv_cycle_i <= (cycles % 4 == 0);
		if (cycles == 30000)
		begin
			errors++;
			print_verdict();
		end
	end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic test_reset;
		rd(ADDR_VCO_CAL, 24'h002205, "cal reset");
		rd(ADDR_PD_CTRL, 24'h07C061, "pd reset");
		rd(ADDR_EXACT, 24'h000000, "exact reset");
		rd(6'h3F, 24'h000000, "unmapped read");
		check("meas reset", 24'h000040, 24'(meas_len));
		check("delay reset", 24'h1, 24'(delay));
		check("up dn reset", 24'h3, 24'({up_en, dn_en}));
		check("gate reset", 24'h3, 24'(gate));
		$display("test reset done");
	endtask : test_reset

	task automatic test_cal_fields;
		int m[8] = '{1, 2, 4, 8, 32, 64, 128, 256};
		int d;
		for (int i = 0; i < 8; i++)
		begin
			d = i + (i << 3) + ((i & 3) << 8) + ((i & 1) << 10) + (((i >> 1) & 1) << 11)
				+ (1 << 12) + ((i & 3) << 13) + (((i >> 2) & 1) << 15) + ((i & 1) << 16);
			wr(ADDR_VCO_CAL, 24'(d));
			check("meas len", 24'(m[i]), 24'(meas_len));
			check("curve", 24'(i < 4 ? i : i - 8), 24'(curve));
			check("sar", 24'(8 - (i & 3)), 24'(sar));
			check("force bypass", 24'({i[0], i[1]}), 24'({force_curve, bypass}));
			check("clock fast", 24'((i & 3) == 0), 24'(fast));
			check("falling", 24'(i[2]), 24'(fall));
			check("rdiv bypass", 24'(i[0]), 24'(rdiv_byp));
			rd(ADDR_VCO_CAL, 24'(d), "cal readback");
		end
		$display("test cal fields done");
	endtask : test_cal_fields

	task automatic test_pd_fields;
		int t[4] = '{0, 5400, 14400, 24100};
		int d;
		for (int i = 0; i < 4; i++)
		begin
			d = i + ((i & 1) << 3) + ((i >> 1) << 4) + ((i & 1) << 5) + ((i >> 1) << 6)
				+ (i << 7) + ((i & 1) << 9) + ((i >> 1) << 10) + ((i & 1) << 11)
				+ 32'h1C000 + (i << 17);
			wr(ADDR_PD_CTRL, 24'(d));
			check("delay", 24'(i), 24'(delay));
			check("short", 24'(i[0]), 24'(shorted));
			check("invert", 24'(i[1]), 24'(invert));
			check("up dn", 24'({i[0], i[1]}), 24'({up_en, dn_en}));
			check("guard", 24'({i != 0, 16'(t[i])}), 24'({guard_en, thr}));
			check("forces", 24'({i[0], i[1], i[0]}), 24'({f_up, f_dn, mid}));
			check("gate", 24'({i != 0, 2'(i)}), 24'({cnt_on, gate}));
		end
		rd(ADDR_PD_CTRL, 24'(d), "pd readback");
		// Every field set, reserved bits at their required values
		wr(ADDR_PD_CTRL, 24'h07CFFF);
		rd(ADDR_PD_CTRL, 24'h07CFFF, "pd fields set");
		$display("test pd fields done");
	endtask : test_pd_fields

	task automatic test_exact;
		logic [13:0] v[4] = '{14'h0000, 14'h0001, 14'h0002, 14'h3FFF};
		for (int i = 0; i < 4; i++)
		begin
			wr(ADDR_EXACT, {10'h3FF, v[i]});
			check("channels", 24'({i > 1, v[i]}), 24'({ex_en, chans}));
		end
		$display("test exact done");
	endtask : test_exact

	task automatic test_transfer(input logic block, input int exp);
		int seen = 0;
		wr(ADDR_VCO_CAL, {11'h000, block, 12'h205});
		@(posedge clock_i);
		reg_write_i <= 1'b1;
		reg_addr_i <= ADDR_TUNE;
		@(posedge clock_i);
		reg_write_i <= 1'b0;
		#1;
		for (int k = 0; k < 5; k++)
		begin
			seen += (tune_xfer === 1'b1);
			@(posedge clock_i);
			#1;
		end
		check("transfer pulses", 24'(exp), 24'(seen));
		$display("test transfer done");
	endtask : test_transfer

	task automatic test_cal(input logic [23:0] cfg, input int wlo, input int whi, input int mlo,
		input int mhi);
		int w = 0;
		int m = 0;
		int k;
		logic r = 1'b0;
		wr(ADDR_VCO_CAL, cfg);
		@(posedge clock_i);
		cal_start_i <= 1'b1;
		@(posedge clock_i);
		cal_start_i <= 1'b0;
		#1;
		for (k = 0; k < 3000 && done !== 1'b1; k++)
		begin
			w += (waiting === 1'b1);
			// Pulse counts when the edge that took it saw the measuring state
			m += (measuring === 1'b1 && r === 1'b1);
			r = rdiv_cycle_i;
			@(posedge clock_i);
			#1;
		end
		m += (measuring === 1'b1 && r === 1'b1);
		check("cal done", 24'h1, 24'(done));
		check_range("wait cycles", wlo, whi, w);
		check_range("measure pulses", mlo, mhi, m);
		$display("test calibration done");
	endtask : test_cal

	initial
	begin
		repeat (6) @(posedge clock_i);
		rst_i <= 1'b0;
		test_reset();
		test_cal_fields();
		test_pd_fields();
		test_exact();
		test_transfer(1'b0, 1);
		test_transfer(1'b1, 0);
		// Direct tick, one divider cycle, five steps, one extra wait
		test_cal(24'h000340, 198, 204, 5, 6);
		// Quarter-rate tick, two divider cycles, five steps, startup wait only
		test_cal(24'h002301, 397, 400, 10, 10);
		// Eight steps, waits after the first three measurements
		test_cal(24'h0000C0, 398, 404, 8, 8);
		// Bypass skips waits and measurements
		test_cal(24'h000800, 0, 0, 0, 0);
		print_verdict();
	end
endmodule : pll_autocal_pd_config_regs_tb
